/* File: design/bsfr_pkg.sv */
// Package with the bank-0 special register map constants and types.
package bsfr_pkg;

	// Number of bank-0 register slots, addresses 0x00 to 0x17.
	localparam int SFR_NUM = 24;

	// Register indices; bank-0 offsets equal the index.
	localparam logic [4:0] IDX_INDIRECT_ACCESS_PORT    = 5'h00;
	localparam logic [4:0] IDX_TIMER_ZERO_COUNT        = 5'h01;
	localparam logic [4:0] IDX_PROGRAM_COUNTER_LOW     = 5'h02;
	localparam logic [4:0] IDX_CORE_STATUS             = 5'h03;
	localparam logic [4:0] IDX_INDIRECT_POINTER        = 5'h04;
	localparam logic [4:0] IDX_PORT_A_IO               = 5'h05;
	localparam logic [4:0] IDX_PORT_B_IO               = 5'h06;
	localparam logic [4:0] IDX_PORT_C_IO               = 5'h07;
	localparam logic [4:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 5'h0a;
	localparam logic [4:0] IDX_INTERRUPT_CONTROL       = 5'h0b;
	localparam logic [4:0] IDX_PERIPHERAL_IRQ_FLAGS    = 5'h0c;
	localparam logic [4:0] IDX_TIMER_ONE_LOW           = 5'h0e;
	localparam logic [4:0] IDX_TIMER_ONE_HIGH          = 5'h0f;
	localparam logic [4:0] IDX_TIMER_ONE_CONTROL       = 5'h10;
	localparam logic [4:0] IDX_TIMER_TWO_COUNT         = 5'h11;
	localparam logic [4:0] IDX_TIMER_TWO_CONTROL       = 5'h12;
	localparam logic [4:0] IDX_SERIAL_PORT_BUFFER      = 5'h13;
	localparam logic [4:0] IDX_SERIAL_PORT_CONTROL     = 5'h14;
	localparam logic [4:0] IDX_CAPTURE_COMPARE_LOW     = 5'h15;
	localparam logic [4:0] IDX_CAPTURE_COMPARE_HIGH    = 5'h16;
	localparam logic [4:0] IDX_CAPTURE_COMPARE_CONTROL = 5'h17;

	// Address bit that selects bank 1 on the register port.
	localparam int BANK_BIT = 7;

	// Status bit positions that are loaded from the reset cause.
	localparam int STATUS_TIMEOUT_BIT  = 4;
	localparam int STATUS_POWERDN_BIT  = 3;

	// Program counter upper width, bits 12:8.
	localparam int PC_HI_W = 5;

	// Value of the hidden upper counter after reset.
	localparam logic [PC_HI_W-1:0] PC_HI_RESET = 5'h00;

	// Implemented bits per slot; a zero mask is an unimplemented slot.
	localparam logic [7:0] SFR_MASK [SFR_NUM] = '{
		8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff,
		8'h00, 8'h00, 8'h1f, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff,
		8'h3f, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f};

	// Bits forced on power-on or brown-out reset; others keep their value.
	localparam logic [7:0] SFR_RST_P [SFR_NUM] = '{
		8'h00, 8'h00, 8'hff, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h1f, 8'hfe, 8'hff, 8'h00, 8'h00, 8'h00,
		8'h3f, 8'hff, 8'h7f, 8'h00, 8'hff, 8'h00, 8'h00, 8'h3f};

	// Values taken by the forced bits on power-on or brown-out reset.
	localparam logic [7:0] SFR_VAL_P [SFR_NUM] = '{
		8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// Bits cleared on master-clear or watchdog reset; bits outside it and SFR_QMASK keep value.
	localparam logic [7:0] SFR_RST_O [SFR_NUM] = '{
		8'h00, 8'h00, 8'hff, 8'he0, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h1f, 8'hfe, 8'hff, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hff, 8'h7f, 8'h00, 8'hff, 8'h00, 8'h00, 8'h3f};

	// Bits loaded from the reset cause on master-clear or watchdog reset.
	localparam logic [7:0] SFR_QMASK [SFR_NUM] = '{
		8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// Whole register file as seen by the peripherals.
	typedef logic [SFR_NUM-1:0][7:0] bsfr_file_t;

	// Peripheral write into one register slot.
	typedef struct packed {
		logic       en;
		logic [4:0] idx;
		logic [7:0] data;
	} bsfr_hw_wr_t;

	// Pin levels returned when a port register is read.
	typedef struct packed {
		logic [5:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} bsfr_pins_t;

endpackage

/* File: design/bsfr_cell.sv */
// One special register slot with per-bit masks and reset encoding.
`timescale 1ns/1ps

module bsfr_cell
	import bsfr_pkg::*;
#(
	parameter logic [7:0] MASK  = 8'hff, // Implemented bits.
	parameter logic [7:0] RST_P = 8'h00, // Bits forced on power-on.
	parameter logic [7:0] VAL_P = 8'h00, // Power-on values of them.
	parameter logic [7:0] RST_O = 8'h00, // Bits cleared on other reset.
	parameter logic [7:0] QMASK = 8'h00  // Bits taken from the cause.
)(
	input  wire logic       clk_in,
	input  wire logic       ce_in,
	input  wire logic       rst_in,
	input  wire logic       por_in,
	input  wire logic [7:0] cause_in,
	input  wire logic       sw_we_in,
	input  wire logic [7:0] sw_d_in,
	input  wire logic       hw_we_in,
	input  wire logic [7:0] hw_d_in,
	output logic      [7:0] q_out
);

	// Next value with the reset encoding and write priority applied.
	logic [7:0] sfr_d;

	// Unlisted bits keep their value; a peripheral write beats software.
	always_comb
	begin
		sfr_d = q_out;
		if (rst_in && por_in)
			sfr_d = (q_out & ~RST_P) | (VAL_P & RST_P);
		else if (rst_in)
			sfr_d = (q_out & ~RST_O & ~QMASK) | (cause_in & QMASK);
		else if (hw_we_in)
			sfr_d = hw_d_in;
		else if (sw_we_in)
			sfr_d = sw_d_in;
		sfr_d = sfr_d & MASK;
	end

	// Static storage that holds unless written or reset.
	always_ff @(posedge clk_in)
	begin
		if (ce_in)
			q_out <= sfr_d;
	end

endmodule

/* File: design/bsfr_regs.sv */
// Bank-0 special register file with bank mirroring and counter latch.
`timescale 1ns/1ps

module bsfr_regs
	import bsfr_pkg::*;
(
	input  wire logic          core_clk_in,
	input  wire logic          rst_in,
	input  wire logic          ce_in,
	input  wire logic          rst_por_in,
	input  wire logic          rst_timeout_in,
	input  wire logic          rst_powerdn_in,
	input  wire logic [7:0]    addr_in,
	input  wire logic [7:0]    wr_data_in,
	input  wire logic          wr_en_in,
	input  wire logic          rd_en_in,
	input  wire bsfr_hw_wr_t   hw_wr_in,
	input  wire bsfr_pins_t    pins_in,
	output logic      [7:0]    rd_data_out,
	output logic      [12:0]   pc_out,
	output bsfr_file_t         sfr_out
);

	// Current contents of every slot, straight from the cell flops.
	bsfr_file_t sfr_q;

	// Hidden upper bits of the program counter.
	logic [PC_HI_W-1:0] pc_hi_q;

	// Next value of the hidden upper bits.
	logic [PC_HI_W-1:0] pc_hi_d;

	// Registered read data and its next value.
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;

	// Value pattern for the status bits loaded from the reset cause.
	logic [7:0] cause_val;

	// Direct address fields of the bus request.
	logic [4:0] bus_idx;
	logic       bus_ok;

	// Request aims at the indirect access port.
	logic       bus_ind;

	// Address after the indirect pointer has been applied.
	logic [7:0] tgt_addr;
	logic [4:0] tgt_idx;
	logic       tgt_ok;

	// Per-slot write enables from software and from peripherals.
	logic [SFR_NUM-1:0] sw_we;
	logic [SFR_NUM-1:0] hw_we;

	// Any write that loads the low counter byte.
	logic       pcl_load;

	// Latch contents as they feed the hidden upper counter.
	logic [PC_HI_W-1:0] latch_bits;

	// Read value of the selected slot before registering.
	logic [7:0] slot_val;

	// True for the slots that answer in both banks.
	function automatic logic is_core(input logic [4:0] idx);
		begin
			is_core = (idx == IDX_INDIRECT_ACCESS_PORT)
				|| (idx == IDX_PROGRAM_COUNTER_LOW)
				|| (idx == IDX_CORE_STATUS)
				|| (idx == IDX_INDIRECT_POINTER)
				|| (idx == IDX_PROGRAM_COUNTER_HIGH_LATCH)
				|| (idx == IDX_INTERRUPT_CONTROL);
		end
	endfunction

	// True when an address lands on a slot of this file.
	// Bank 0 reaches every slot; bank 1 reaches only the core slots.
	// Addresses from 0x18 to 0x7f lie outside this file.
	function automatic logic addr_hit(input logic [7:0] a);
		logic low;
		begin
			low = (a[6:5] == 2'b00) && (a[4:0] < 5'(SFR_NUM));
			addr_hit = low && (!a[BANK_BIT] || is_core(a[4:0]));
		end
	endfunction

	// Cause pattern for the timeout and power-down status bits.
	assign cause_val = {3'b000, rst_timeout_in, rst_powerdn_in, 3'b000};

	// Decode of the direct address on the register port.
	assign bus_idx = addr_in[4:0];
	assign bus_ok  = addr_hit(addr_in);

	// The indirect port is no storage; it redirects through the pointer.
	assign bus_ind = bus_ok && (bus_idx == IDX_INDIRECT_ACCESS_PORT);

	// Effective address after indirection.
	assign tgt_addr = bus_ind ? sfr_q[IDX_INDIRECT_POINTER] : addr_in;
	assign tgt_idx  = tgt_addr[4:0];

	// An indirect access that points at the indirect port finds nothing.
	assign tgt_ok = addr_hit(tgt_addr)
		&& (tgt_idx != IDX_INDIRECT_ACCESS_PORT);

	// One register slot per index, shaped by the package tables.
	for (genvar i = 0; i < SFR_NUM; i++)
	begin : g_slot
		// Software write to this slot through the port.
		assign sw_we[i] = wr_en_in && tgt_ok && (tgt_idx == 5'(i));

		// Peripheral write to this slot.
		assign hw_we[i] = hw_wr_in.en && (hw_wr_in.idx == 5'(i));

		bsfr_cell #(
			.MASK  (SFR_MASK[i]),
			.RST_P (SFR_RST_P[i]),
			.VAL_P (SFR_VAL_P[i]),
			.RST_O (SFR_RST_O[i]),
			.QMASK (SFR_QMASK[i])
		) u_cell (
			.clk_in   (core_clk_in),
			.ce_in    (ce_in),
			.rst_in   (rst_in),
			.por_in   (rst_por_in),
			.cause_in (cause_val),
			.sw_we_in (sw_we[i]),
			.sw_d_in  (wr_data_in),
			.hw_we_in (hw_we[i]),
			.hw_d_in  (hw_wr_in.data),
			.q_out    (sfr_q[i])
		);
	end

	// Peripherals see the whole file at once.
	assign sfr_out = sfr_q;

	// The low counter byte is loaded by software or by the core.
	assign pcl_load = sw_we[IDX_PROGRAM_COUNTER_LOW]
		|| hw_we[IDX_PROGRAM_COUNTER_LOW];

	// Latch bits that transfer into the hidden upper counter.
	assign latch_bits = sfr_q[IDX_PROGRAM_COUNTER_HIGH_LATCH][PC_HI_W-1:0];

	// Upper counter takes the latch whenever the low byte is loaded.
	// The latch value is the one held before this cycle's write.
	always_comb
	begin
		pc_hi_d = pc_hi_q;
		if (rst_in)
			pc_hi_d = PC_HI_RESET;
		else if (pcl_load)
			pc_hi_d = latch_bits;
	end

	// Hidden upper counter; no address reaches it.
	always_ff @(posedge core_clk_in)
	begin
		if (ce_in)
			pc_hi_q <= pc_hi_d;
	end

	// Full counter for the core.
	assign pc_out = {pc_hi_q, sfr_q[IDX_PROGRAM_COUNTER_LOW]};

	// Value of the addressed slot; ports return their pin levels.
	always_comb
	begin
		case (tgt_idx)
			IDX_PORT_A_IO:
				slot_val = {2'b00, pins_in.a};
			IDX_PORT_B_IO:
				slot_val = pins_in.b;
			IDX_PORT_C_IO:
				slot_val = pins_in.c;
			default:
				slot_val = sfr_q[tgt_idx];
		endcase
	end

	// Read data for the cycle after the strobe and zero otherwise.
	always_comb
	begin
		rd_data_d = 8'h00;
		if (rd_en_in && tgt_ok)
			rd_data_d = slot_val & SFR_MASK[tgt_idx];
	end

	// Read data register; it stands for one cycle only.
	// Reset acts only with the enable high, like every other flop here.
	always_ff @(posedge core_clk_in)
	begin
		if (ce_in)
			rd_data_q <= rst_in ? 8'h00 : rd_data_d;
	end

	// Read data leaves straight from its flop.
	assign rd_data_out = rd_data_q;

endmodule

/* File: tb/bsfr_checker.sv */
// Assertion checker watching the ports of the bank-0 register file.
`timescale 1ns/1ps
module bsfr_checker
	import bsfr_pkg::*;
(
	input wire logic        core_clk_in,
	input wire logic        rst_in,
	input wire logic        ce_in,
	input wire logic        rst_por_in,
	input wire logic        rst_timeout_in,
	input wire logic        rst_powerdn_in,
	input wire logic [7:0]  addr_in,
	input wire logic [7:0]  wr_data_in,
	input wire logic        wr_en_in,
	input wire logic        rd_en_in,
	input wire bsfr_hw_wr_t hw_wr_in,
	input wire bsfr_pins_t  pins_in,
	input wire logic [7:0]  rd_data_out,
	input wire logic [12:0] pc_out,
	input wire bsfr_file_t  sfr_out
);
	// Offset, mirrored core slots, empty slots and software-only writes.
	wire [6:0] off = addr_in[6:0];
	wire core = off inside {7'h02, 7'h03, 7'h04, 7'h0a, 7'h0b};
	wire gap = off inside {7'h08, 7'h09, 7'h0d} || off > 7'h17;
	wire sw = !hw_wr_in.en && ce_in;
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// Software write of the counter low byte from either bank.
	sequence s_pcl_wr;
		sw && wr_en_in && off == 7'h02;
	endsequence
	property p_gap_rd;
		ce_in && rd_en_in && gap |=> rd_data_out == 8'h00;
	endproperty
	a_gap_rd: assert property (p_gap_rd) else $error("empty slot read not zero");
	property p_b1_rd;
		ce_in && rd_en_in && addr_in[7] && !core && off != 7'h00 |=> rd_data_out == 8'h00;
	endproperty
	a_b1_rd: assert property (p_b1_rd) else $error("bank one read not zero");
	property p_mirror_wr;
		sw && wr_en_in && core |=> sfr_out[$past(off[4:0])]
			== ($past(wr_data_in) & ($past(off) == 7'h0a ? 8'h1f : 8'hff));
	endproperty
	a_mirror_wr: assert property (p_mirror_wr) else $error("core write lost");
	property p_pc_load;
		s_pcl_wr |=> pc_out == {$past(sfr_out[10][4:0]), $past(wr_data_in)};
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("counter load wrong");
	property p_pc_hold;
		sw && !(wr_en_in && (off == 7'h02 || off == 7'h00)) |=> $stable(pc_out[12:8]);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("upper counter moved");
	property p_b1_wr;
		sw && wr_en_in && addr_in[7] && !core && off != 7'h00 && off < 7'h18
			|=> sfr_out[$past(off[4:0])] == $past(sfr_out[off[4:0]]);
	endproperty
	a_b1_wr: assert property (p_b1_wr) else $error("bank one write landed");
	property p_por;
		disable iff (1'b0) rst_in && ce_in && rst_por_in
			|=> sfr_out[3][7:3] == 5'h03 && pc_out == 13'h0000;
	endproperty
	a_por: assert property (p_por) else $error("power-on status wrong");
	property p_oth;
		disable iff (1'b0) rst_in && ce_in && !rst_por_in
			|=> sfr_out[3][7:3] == {3'h0, $past(rst_timeout_in), $past(rst_powerdn_in)};
	endproperty
	a_oth: assert property (p_oth) else $error("other reset status wrong");
	// With the enable low no register and no output may move.
	property p_ce_hold;
		!ce_in |=> $stable(sfr_out) && $stable(pc_out) && $stable(rd_data_out);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with enable low");
	// A peripheral write lands masked, ahead of any software write.
	property p_hw_wr;
		ce_in && hw_wr_in.en && hw_wr_in.idx < 5'h18 |=> sfr_out[$past(hw_wr_in.idx)]
			== ($past(hw_wr_in.data) & SFR_MASK[$past(hw_wr_in.idx)]);
	endproperty
	a_hw_wr: assert property (p_hw_wr) else $error("peripheral write lost");
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the bank-0 special register file.
`timescale 1ns/1ps
module tb_top
	import bsfr_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, por = 1'b1, tmo = 1'b0, pdn = 1'b0;
	logic        we = 1'b0, re = 1'b0, rv = 1'b0, ce = 1'b1;
	bsfr_hw_wr_t hw = '0;
	logic [7:0]  ad = 8'h00, wd = 8'h00, rdo, rx;
	logic [12:0] pc, epc;
	logic [4:0]  pch;
	bsfr_pins_t  pv = '0, pn = '0;
	logic [7:0]  m [SFR_NUM];
	int          cl [7] = '{2, 10, 12, 17, 18, 20, 23};
	int          errors = 0, checks = 0;
	always #2 clk = ~clk;
	bsfr_regs DUT (.core_clk_in(clk), .rst_in(rst), .ce_in(ce), .rst_por_in(por),
		.rst_timeout_in(tmo), .rst_powerdn_in(pdn), .addr_in(ad), .wr_data_in(wd),
		.wr_en_in(we), .rd_en_in(re), .hw_wr_in(hw), .pins_in(pn), .rd_data_out(rdo),
		.pc_out(pc), .sfr_out());
	// Indirect offset takes the pointer as the full address.
	function automatic logic [7:0] res(input logic [7:0] a);
		return (a[6:0] == 7'h00) ? m[4] : a;
	endfunction
	// True for a stored slot reachable at this address.
	function automatic bit ok(input logic [7:0] b);
		return b[6:0] != 7'h00 && b[6:0] < 7'h18
			&& (!b[7] || b[6:0] inside {7'h02, 7'h03, 7'h04, 7'h0a, 7'h0b});
	endfunction
	// Expected read value; ports return the pins.
	function automatic logic [7:0] ev(input logic [7:0] b);
		if (!ok(b))
			return 8'h00;
		case (b[6:0])
			7'h05:   return {2'h0, pv.a};
			7'h06:   return pv.b;
			7'h07:   return pv.c;
			default: return m[b[4:0]];
		endcase
	endfunction
	task automatic check(input logic [12:0] s, input logic [12:0] e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] b;
		b = res(a);
		if (ok(b) && b[6:0] == 7'h03)
			d = d & 8'h3f;
		if (ok(b))
		begin
			if (b[6:0] == 7'h02)
				pch = m[10][4:0];
			m[b[4:0]] = d & SFR_MASK[b[4:0]];
		end
		ad <= a;
		wd <= d;
		we <= 1'b1;
		re <= 1'b0;
		@(posedge clk);
		epc = {pch, m[2]};
	endtask
	task automatic rd(input logic [7:0] a);
		logic [7:0] e;
		e = ev(res(a));
		ad <= a;
		re <= 1'b1;
		we <= 1'b0;
		@(posedge clk);
		rx = e;
		rv = 1'b1;
	endtask
	// Reset for four cycles, then apply the reset values to the model.
	task automatic rstk(input logic p, input logic t, input logic d);
		we <= 1'b0;
		re <= 1'b0;
		if (!rst)
			@(posedge clk);
		rst <= 1'b1;
		por <= p;
		tmo <= t;
		pdn <= d;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (cl[i])
			m[cl[i]] = 8'h00;
		if (p)
			m[16] = 8'h00;
		m[11] = m[11] & 8'h01;
		m[3] = {p ? 5'h03 : {3'h0, t, d}, m[3][2:0]};
		pch = 5'h00;
		epc = 13'h0000;
	endtask
	task automatic sweep;
		for (int i = 0; i < 64; i++)
			rd({i[5], 2'h0, i[4:0]});
	endtask
	task automatic end_of_test;
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Read data stand one cycle after the strobe, zero otherwise.
	always @(negedge clk)
	begin
		if (!rst)
		begin
			check(13'(rdo), 13'(rv ? rx : 8'h00));
			check(pc, epc);
			rv = 1'b0;
		end
	end
	initial
	begin
		logic [31:0] r;
		r = $urandom(32'h57c0);
		rstk(1'b1, 1'b0, 1'b0);
		for (int i = 1; i < 24; i++)
			wr(8'(i), 8'($urandom));
		sweep();
		for (int n = 0; n < 600; n++)
		begin
			r = $urandom;
			pv = bsfr_pins_t'(r[21:0]);
			pn <= pv;
			if (r[31])
				wr({r[30], 2'h0, r[29:25]}, 8'($urandom));
			else
				rd({r[30], 2'h0, r[29:25]});
		end
		wr(8'h0a, 8'hff);
		wr(8'h82, 8'h34);
		wr(8'h04, 8'h02);
		// Enable low for three edges: a pending counter write must not land.
		ce <= 1'b0;
		ad <= 8'h02;
		wd <= 8'h77;
		we <= 1'b1;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		wr(8'h80, 8'h5a);
		// Peripheral and software write the counter low byte together.
		pch = m[10][4:0];
		m[2] = 8'h11;
		hw <= {1'b1, 5'h02, 8'h11};
		wd <= 8'h22;
		ad <= 8'h02;
		@(posedge clk);
		epc = {pch, m[2]};
		hw <= '0;
		rd(8'h8a);
		wr(8'h04, 8'h80);
		rd(8'h00);
		rstk(1'b0, 1'b1, 1'b0);
		sweep();
		rstk(1'b0, 1'b0, 1'b1);
		sweep();
		rstk(1'b1, 1'b1, 1'b1);
		sweep();
		we <= 1'b0;
		re <= 1'b0;
		repeat (2) @(negedge clk);
		end_of_test();
	end
	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		end_of_test();
	end
endmodule
bind bsfr_regs bsfr_checker u_chk (.core_clk_in, .rst_in, .ce_in, .rst_por_in,
	.rst_timeout_in, .rst_powerdn_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
	.hw_wr_in, .pins_in, .rd_data_out, .pc_out, .sfr_out);
